// *** core/clk_sel_pkg.sv ***
// Package: shared constants and carriers for the input monitor and selector
// Assumes one 10 MHz master clock and Avalon-MM register access
package clk_sel_pkg;
	localparam int          NUM_INPUTS      = 3;
	localparam int          ADDR_W          = 4;
	localparam int          CLK_MHZ         = 10;

	// Register byte offsets
	localparam logic [3:0]  OFF_CTRL        = 4'h0;
	localparam logic [3:0]  OFF_PRIO        = 4'h4;
	localparam logic [3:0]  OFF_STATUS      = 4'h8;
	localparam logic [3:0]  OFF_TABLE       = 4'hc;

	// Field layout of the per-input config word
	localparam int          POL_BIT         = 0;
	localparam int          ACT_EN_BIT      = 1;
	localparam int          PCT_EN_BIT      = 2;
	localparam int          MAN_VAL_BIT     = 3;
	localparam int          LOS_SEL_LSB     = 4;

	// Reset values
	localparam logic [3:0]  PRIO_RST [NUM_INPUTS] = '{4'h1, 4'h2, 4'h3};
	localparam logic [4:0]  PCT_RST         = 5'h05;
	localparam logic [15:0] TIMED_VALID_RST        = 16'h0000;
	localparam logic [15:0] LOCK_TIMEOUT_FLAG_RST        = 16'h0000;
	localparam logic [7:0]  CFG_RST         = 8'h08;
	localparam logic [15:0] EXPECT_RST      = 16'h0064;

	// Time units: activity window and lock timeout count master clocks
	localparam int          WIN_US          = 100;
	localparam int          WIN_CYC         = WIN_US * CLK_MHZ;

	typedef struct packed {
		logic       act_ok;
		logic       pct_ok;
		logic       los;
		logic       all_ok;
		logic       timed_ok;
		logic       lock_timeout_flag;
	} mon_status_type;

	typedef struct packed {
		logic [1:0] top_ranked_input;
		logic [1:0] selected;
		logic [1:0] second;
		logic [1:0] third;
	} table_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_DONE = 3'b100
	} bus_state_type;

	function automatic logic [1:0] idx_code(input int i);
		idx_code = 2'(i + 1);
	endfunction
endpackage

// *** core/clk_selector.sv ***
// What this block does
// [RULE1] Per-input polarity bit picks the lock edge; rising after reset.
// [RULE2] Software keeps the divided input frequency below 250MHz.
// [RULE3] Software keeps enabled inputs dividing to one common detector rate.
// [RULE4] Activity monitor counts input edges over a fixed window.
// [RULE5] Activity status low when stopped or far too fast.
// [RULE6] Percent monitor checks frequency within 1 to 20 percent.
// [RULE7] Failing input shows invalid; any change sets a latched bit.
// [RULE8] Manually invalidated inputs are never auto-selected.
// [RULE9] Each monitor has an enable; disabled means valid.
// [RULE10] Lock timeout on selected input invalidates it and flags it.
// [RULE11] Any pin may be loss source; loss invalidates at once.
// [RULE12] Loss forces both monitors invalid; activity fail forces percent fail.
// [RULE13] Lower monitor validates only after higher one says valid.
// [RULE14] Timer holds all-valid for set time before timed valid.
// [RULE15] Priority zero disables an input; one is highest.
// [RULE16] Reset priorities are 1, 2 and 3.
// [RULE17] With pin switch mode off, highest-priority valid input is chosen.
// [RULE18] Table reports top and selected, then second and third.
// [RULE19] Equal priorities rotate circularly; no revertive_select among them.
// [RULE20] Revertive_select on: newly valid higher priority takes over at once.
// [RULE21] Revertive_select off: it tops the table; pulsing revertive_select forces switch.
// [RULE22] Loss of selected reference switches to best valid input.
// [RULE23] Latched bits clear by writing one; set beats clear.
// File holds the top: Avalon-MM slave, selector and lock timeout
// Assumes master clock clk_in; input clocks and pins are asynchronous
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module clk_selector
#(
	parameter int GPIO_N = 4
)
(
	// Clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	// Reference clocks, pins, loop lock
	input  wire logic [2:0]            ref_clk_in,
	input  wire logic [GPIO_N-1:0]     gpio_in,
	input  wire logic                  dpll_locked_in,
	// Avalon-MM slave
	input  wire logic [3:0]            address_in,
	input  wire logic                  read_in,
	input  wire logic                  write_in,
	input  wire logic [31:0]           writedata_in,
	output logic      [31:0]           readdata_out,
	output logic                       waitrequest_out,
	// Selection to the loop
	output logic      [1:0]            sel_ref_out,
	output logic                       sel_valid_out
);
	import clk_sel_pkg::*;

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	logic [7:0]  cfg_r [3], cfg_nxt [3];
	logic [3:0]  prio_r [3], prio_nxt [3];
	logic        revertive_select_r, revertive_select_nxt, pinsw_r, pinsw_nxt;
	logic [4:0]  pct_r, pct_nxt;
	logic [15:0] timed_valid_r, timed_valid_nxt, lock_timeout_flag_set_r, lock_timeout_flag_set_nxt;
	logic [15:0] expect_r, expect_nxt;
	logic [2:0]  latch_r, latch_nxt, prev_val_r, prev_val_nxt;
	logic [2:0]  lock_timeout_flag_r, lock_timeout_flag_nxt;
	logic [15:0] lk_cnt_r, lk_cnt_nxt;
	logic [1:0]  sel_r, sel_nxt;
	logic        selv_r, selv_nxt, wait_r, wait_nxt;
	logic [1:0]  gs1_r [3], gs2_r [3];
	table_type   tab_r, tab_nxt;
	logic [31:0] rd_r, rd_nxt;
	bus_state_type bst_r, bst_nxt;
	mon_status_type st_w [3];
	logic [2:0]  valid_w, avail_w, gpio_sel;

	// ----------------------------------------
	// Monitors and loss source selection
	// ----------------------------------------
	for (genvar i = 0; i < 3; i++)
	begin : g_mon
		logic [1:0] los_idx;
		assign los_idx     = cfg_r[i][LOS_SEL_LSB+1:LOS_SEL_LSB];
		assign gpio_sel[i] = cfg_r[i][7] & gs2_r[i][0]; // [RULE11]
		always_ff @(posedge clk_in)
		begin
			if (rst_in)
			begin
				gs1_r[i] <= 2'h0;
				gs2_r[i] <= 2'h0;
			end
			else
			begin
				gs1_r[i] <= {1'b0, gpio_in[los_idx]};
				gs2_r[i] <= gs1_r[i];
			end
		end
		input_monitor u_mon (
			.clk_in    (clk_in),
			.rst_in    (rst_in),
			.ref_in    (ref_clk_in[i]),
			.los_in    (gpio_sel[i]),
			.pol_in    (cfg_r[i][POL_BIT]),
			.act_en_in (cfg_r[i][ACT_EN_BIT]),
			.pct_en_in (cfg_r[i][PCT_EN_BIT]),
			.pct_in    (pct_r),
			.expect_in (expect_r),
			.timed_valid_in   (timed_valid_r),
			.st_out    (st_w[i])
		);
		// Valid means timed valid and no lock timeout against it
		assign valid_w[i] = st_w[i].timed_ok & ~lock_timeout_flag_r[i]; // [RULE7] [RULE10]
		assign avail_w[i] = valid_w[i] & cfg_r[i][MAN_VAL_BIT]
		                    & (prio_r[i] != 4'h0); // [RULE8] [RULE15]
	end

	// Rank key: lower is better; unavailable gets worst value
	function automatic logic [4:0] key(input logic a, input logic [3:0] p);
		key = a ? {1'b0, p} : 5'h1f;
	endfunction

	// ----------------------------------------
	// Selector
	// ----------------------------------------
	always_comb
	begin
		logic [1:0] ord [3];
		logic [1:0] t;
		logic [1:0] best;
		logic [1:0] cur;
		logic       cur_ok;
		ord = '{2'd0, 2'd1, 2'd2};
		t   = 2'd0;
		best   = 2'd0;
		cur_ok = 1'b0;
		cur = sel_r - 2'd1;
		// Rotate start so ties follow a circular list after the current
		for (int k = 0; k < 3; k++)
			ord[k] = 2'((int'(cur) + 1 + k) % 3);
		// Stable sort of three keys
		for (int a = 0; a < 2; a++)
			for (int b = 0; b < 2 - a; b++)
				if (key(avail_w[ord[b+1]], prio_r[ord[b+1]])
				    < key(avail_w[ord[b]], prio_r[ord[b]]))
				begin
					t        = ord[b];
					ord[b]   = ord[b+1];
					ord[b+1] = t;
				end // [RULE19]
		best   = ord[0];
		cur_ok = (sel_r != 2'd0) && avail_w[cur];
		tab_nxt.top_ranked_input = avail_w[best] ? idx_code(int'(best)) : 2'd0;
		tab_nxt.second = avail_w[ord[1]] ? idx_code(int'(ord[1])) : 2'd0;
		tab_nxt.third  = avail_w[ord[2]] ? idx_code(int'(ord[2])) : 2'd0; // [RULE18]
		sel_nxt = sel_r;
		if (!pinsw_r) // [RULE17]
		begin
			if (!cur_ok)
				sel_nxt = tab_nxt.top_ranked_input; // [RULE22]
			else if (revertive_select_r && prio_r[best] < prio_r[cur])
				sel_nxt = tab_nxt.top_ranked_input; // [RULE20] [RULE21]
		end
		tab_nxt.selected = sel_nxt;
		selv_nxt = (sel_nxt != 2'd0);
	end

	// ----------------------------------------
	// Lock timeout and latched change bits
	// ----------------------------------------
	always_comb
	begin
		lk_cnt_nxt   = 16'h0000;
		lock_timeout_flag_nxt     = lock_timeout_flag_r;
		prev_val_nxt = valid_w;
		latch_nxt    = latch_r;
		// Clear first so that an event in the same cycle still sets
		if (write_in && !wait_r && address_in == OFF_STATUS)
		begin
			latch_nxt = latch_r & ~writedata_in[4:2];
			lock_timeout_flag_nxt  = lock_timeout_flag_r & ~writedata_in[10:8];
		end
		if (sel_r != 2'd0 && !dpll_locked_in && lock_timeout_flag_set_r != 16'h0000)
		begin
			lk_cnt_nxt = lk_cnt_r + 16'h0001;
			if (lk_cnt_r == lock_timeout_flag_set_r)
			begin
				lock_timeout_flag_nxt[sel_r-2'd1] = 1'b1; // [RULE10]
				lk_cnt_nxt = 16'h0000;
			end
		end
		if (sel_nxt != sel_r)
			lk_cnt_nxt = 16'h0000;
		latch_nxt = latch_nxt | (valid_w ^ prev_val_r); // [RULE7] [RULE23]
	end

	// ----------------------------------------
	// Avalon-MM slave: two wait cycles then answer
	// ----------------------------------------
	always_comb
	begin
		bst_nxt      = bst_r;
		rd_nxt       = rd_r;
		cfg_nxt      = cfg_r;
		prio_nxt     = prio_r;
		revertive_select_nxt   = revertive_select_r;
		pinsw_nxt    = pinsw_r;
		pct_nxt      = pct_r;
		timed_valid_nxt     = timed_valid_r;
		lock_timeout_flag_set_nxt = lock_timeout_flag_set_r;
		expect_nxt   = expect_r;
		case (bst_r)
			ST_IDLE:
				if (read_in || write_in)
					bst_nxt = ST_WAIT;
			ST_WAIT:
			begin
				bst_nxt = ST_DONE;
				rd_nxt  = 32'h0000_0000;
				case (address_in)
					OFF_CTRL:
						rd_nxt = {cfg_r[2], cfg_r[1], cfg_r[0],
						          revertive_select_r, pinsw_r, 1'b0, pct_r};
					OFF_PRIO:
						rd_nxt = {expect_r, 4'h0, prio_r[2], prio_r[1],
						          prio_r[0]};
					OFF_STATUS:
						rd_nxt = {lock_timeout_flag_r, 2'h0, valid_w, 1'b0,
						          st_w[2], st_w[1], st_w[0],
						          latch_r, 2'h0}; // [RULE7]
					OFF_TABLE:
						rd_nxt = {lock_timeout_flag_set_r, timed_valid_r[7:0], tab_r}; // [RULE18]
					default:
						rd_nxt = 32'h0000_0000;
				endcase
			end
			ST_DONE:
			begin
				bst_nxt = ST_IDLE;
				// A write lands at the edge where waitrequest is seen low
				if (write_in)
				begin
					case (address_in)
						OFF_CTRL:
						begin
							pct_nxt    = writedata_in[4:0];
							pinsw_nxt  = writedata_in[6];
							revertive_select_nxt = writedata_in[7];
							cfg_nxt[0] = writedata_in[15:8];
							cfg_nxt[1] = writedata_in[23:16];
							cfg_nxt[2] = writedata_in[31:24];
						end
						OFF_PRIO:
						begin
							prio_nxt[0] = writedata_in[3:0];
							prio_nxt[1] = writedata_in[7:4];
							prio_nxt[2] = writedata_in[11:8];
							expect_nxt  = writedata_in[31:16];
						end
						OFF_TABLE:
						begin
							timed_valid_nxt     = {8'h00, writedata_in[15:8]};
							lock_timeout_flag_set_nxt = writedata_in[31:16];
						end
						default:
							timed_valid_nxt = timed_valid_r;
					endcase
				end
			end
			default:
				bst_nxt = ST_IDLE;
		endcase
		if (pct_nxt == 5'h00)
			pct_nxt = 5'h01;
		else if (pct_nxt > 5'd20)
			pct_nxt = 5'd20; // [RULE6]
		wait_nxt = (bst_nxt != ST_DONE);
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			bst_r        <= ST_IDLE;
			rd_r         <= 32'h0000_0000;
			cfg_r        <= '{CFG_RST, CFG_RST, CFG_RST}; // [RULE1]
			prio_r       <= PRIO_RST; // [RULE16]
			revertive_select_r     <= 1'b0;
			pinsw_r      <= 1'b0;
			pct_r        <= PCT_RST;
			timed_valid_r       <= TIMED_VALID_RST;
			lock_timeout_flag_set_r   <= LOCK_TIMEOUT_FLAG_RST;
			expect_r     <= EXPECT_RST;
			latch_r      <= 3'h0;
			prev_val_r   <= 3'h0;
			lock_timeout_flag_r       <= 3'h0;
			lk_cnt_r     <= 16'h0000;
			sel_r        <= 2'd0;
			tab_r        <= '0;
			selv_r       <= 1'b0;
			wait_r       <= 1'b1;
		end
		else
		begin
			bst_r        <= bst_nxt;
			rd_r         <= rd_nxt;
			cfg_r        <= cfg_nxt;
			prio_r       <= prio_nxt;
			revertive_select_r     <= revertive_select_nxt;
			pinsw_r      <= pinsw_nxt;
			pct_r        <= pct_nxt;
			timed_valid_r       <= timed_valid_nxt;
			lock_timeout_flag_set_r   <= lock_timeout_flag_set_nxt;
			expect_r     <= expect_nxt;
			latch_r      <= latch_nxt;
			prev_val_r   <= prev_val_nxt;
			lock_timeout_flag_r       <= lock_timeout_flag_nxt;
			lk_cnt_r     <= lk_cnt_nxt;
			sel_r        <= sel_nxt;
			tab_r        <= tab_nxt;
			selv_r       <= selv_nxt;
			wait_r       <= wait_nxt;
		end
	end

	assign readdata_out    = rd_r;
	assign waitrequest_out = wait_r;
	assign sel_ref_out     = sel_r;
	assign sel_valid_out   = selv_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_sel_available: assert property (@(posedge clk_in) disable iff (rst_in)
		sel_r != 2'd0 && !avail_w[sel_r-2'd1] && !pinsw_r |=>
		sel_r != $past(sel_r))
		else $error("selected unavailable"); // [RULE22]
	a_never_manual: assert property (@(posedge clk_in) disable iff (rst_in)
		sel_nxt != 2'd0 && sel_nxt != sel_r |->
		cfg_r[sel_nxt-2'd1][MAN_VAL_BIT] && prio_r[sel_nxt-2'd1] != 4'h0)
		else $error("manual-invalid input chosen"); // [RULE8] [RULE15]
	a_change_latch: assert property (@(posedge clk_in) disable iff (rst_in)
		valid_w != prev_val_r |=> (latch_r & $past(valid_w ^ prev_val_r))
		== $past(valid_w ^ prev_val_r))
		else $error("change not latched"); // [RULE7]
	a_latch_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
		latch_r[0] && !(write_in && address_in == OFF_STATUS) |=> latch_r[0])
		else $error("latched bit dropped"); // [RULE23]
	a_bus_answer: assert property (@(posedge clk_in) disable iff (rst_in)
		bst_r == ST_IDLE && (read_in || write_in) |=> ##1 !waitrequest_out)
		else $error("bus answer late"); // Avalon-MM slave: two wait cycles then answer
endmodule
`default_nettype wire

// *** core/input_monitor.sv ***
// Per-input monitor chain: activity, percent monitor and validation timer
// Assumes ref_in from a pin; synchronised here before use
`timescale 1ns/1ns
`default_nettype none
module input_monitor
(
	// Clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 rst_in,
	// Input clock and loss indicator
	input  wire logic                 ref_in,
	input  wire logic                 los_in,
	// Configuration
	input  wire logic                 pol_in,
	input  wire logic                 act_en_in,
	input  wire logic                 pct_en_in,
	input  wire logic [4:0]           pct_in,
	input  wire logic [15:0]          expect_in,
	input  wire logic [15:0]          timed_valid_in,
	// Status
	output var clk_sel_pkg::mon_status_type st_out
);
	import clk_sel_pkg::*;

	logic [2:0]  sync_r, sync_nxt;
	logic [15:0] win_r, win_nxt, cnt_r, cnt_nxt, tmr_r, tmr_nxt;
	logic        act_r, act_nxt, pct_r, pct_nxt;
	mon_status_type st_r, st_nxt;
	logic        edge_w, win_end;
	logic [21:0] tol;
	logic [15:0] lo_lim, hi_lim;

	always_comb
	begin
		sync_nxt = {sync_r[1:0], ref_in};
		// Edge follows the chosen lock polarity
		edge_w   = pol_in ? (sync_r[2] & ~sync_r[1])
		                  : (~sync_r[2] & sync_r[1]); // [RULE1]
		win_end  = (win_r == 16'(WIN_CYC - 1));
		win_nxt  = win_end ? 16'h0000 : win_r + 16'h0001;
		cnt_nxt  = win_end ? 16'h0000 : cnt_r + {15'h0000, edge_w}; // [RULE4]
		tol      = 22'(expect_in * pct_in) / 22'd100;
		lo_lim   = expect_in - tol[15:0];
		hi_lim   = expect_in + tol[15:0];
		act_nxt  = act_r;
		pct_nxt  = pct_r;
		if (win_end)
		begin
			// Zero or far too many edges fails activity
			act_nxt = (cnt_r != 16'h0000) && (cnt_r <= {expect_in[14:0], 1'b0}); // [RULE5]
			pct_nxt = (cnt_r >= lo_lim) && (cnt_r <= hi_lim); // [RULE6]
		end
		st_nxt        = st_r;
		st_nxt.los    = los_in; // [RULE11]
		st_nxt.act_ok = ~los_in & (~act_en_in | act_nxt); // [RULE9] [RULE12]
		st_nxt.pct_ok = st_nxt.act_ok & (~pct_en_in | pct_nxt); // [RULE12] [RULE13]
		st_nxt.all_ok = st_nxt.act_ok & st_nxt.pct_ok;
		st_nxt.lock_timeout_flag   = 1'b0;
		tmr_nxt       = st_nxt.all_ok ? tmr_r : 16'h0000;
		if (st_nxt.all_ok && tmr_r != timed_valid_in)
			tmr_nxt = tmr_r + 16'h0001;
		st_nxt.timed_ok = st_nxt.all_ok && (tmr_r == timed_valid_in); // [RULE14]
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			sync_r <= 3'h0;
			win_r  <= 16'h0000;
			cnt_r  <= 16'h0000;
			tmr_r  <= TIMED_VALID_RST;
			act_r  <= 1'b0;
			pct_r  <= 1'b0;
			st_r   <= '0;
		end
		else
		begin
			sync_r <= sync_nxt;
			win_r  <= win_nxt;
			cnt_r  <= cnt_nxt;
			tmr_r  <= tmr_nxt;
			act_r  <= act_nxt;
			pct_r  <= pct_nxt;
			st_r   <= st_nxt;
		end
	end

	assign st_out = st_r;

	a_timed_needs_all: assert property (@(posedge clk_in) disable iff (rst_in)
		st_r.timed_ok |-> st_r.all_ok) else $error("timed valid without all ok"); // [RULE14]
	a_los_kills_act: assert property (@(posedge clk_in) disable iff (rst_in)
		los_in |=> !st_r.act_ok && !st_r.pct_ok) else $error("los not forcing invalid"); // [RULE12]
	a_act_gates_pct: assert property (@(posedge clk_in) disable iff (rst_in)
		!st_r.act_ok |-> !st_r.pct_ok) else $error("pct valid under act fail"); // [RULE13]
	a_disabled_valid: assert property (@(posedge clk_in) disable iff (rst_in)
		!los_in && !act_en_in && !pct_en_in |=> st_r.all_ok) else $error("disabled monitors not valid"); // [RULE9]
endmodule
`default_nettype wire

// *** verif/ref_src.sv ***
// Model of the reference clock sources that feed the input block
// Assumes half periods in ns; a zero half period holds the clock low
`timescale 1ns/1ns
`default_nettype none
module ref_src
(
	// Half periods per input
	input  wire logic [15:0] half_in [3],
	// Reference clocks
	output var  logic [2:0]  clk_out
);
	// ------------------------------
	// Clock generators
	// ------------------------------
	initial clk_out = 3'h0;
	for (genvar i = 0; i < 3; i++)
	begin : gen_src
		// Half period of input i lengthened by i ns, so inputs 1 and 2 drift against the master clock phase; input 0 has none
		always
		begin
			if (half_in[i] == 16'h0000)
				#100 clk_out[i] = 1'b0;
			else
				#(half_in[i] + i) clk_out[i] = ~clk_out[i];
		end
	end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the input monitor and reference selector
// Assumes ref_src drives the input clocks; registers over Avalon-MM
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import clk_sel_pkg::*;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [2:0]  ref_clk;
	logic [3:0]  gpio = 4'h0;
	logic        locked = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] q;
	logic        wreq;
	logic [1:0]  sel;
	logic        selv;
	logic [15:0] half [3] = '{16'd500, 16'd500, 16'd500};
	int          mismatches = 0;
	int          checks_done = 0;
	int          seed = 91661;
	int          prio [3] = '{1, 2, 3};
	int          man [3] = '{1, 1, 1};
	int          mon [3] = '{1, 1, 1};
	int          los [3] = '{0, 0, 0};
	int          val [3] = '{1, 1, 1};
	int          cur = 0;
	int          rev = 0;
	int          psw = 0;
	int          pct;
	int          lock_edge_polarity;

	// ------------------------------
	// Clock, design and sources
	// ------------------------------
	always #50 clk_in = ~clk_in;
	clk_selector #(.GPIO_N(4)) clk_selector_inst
	(
		.clk_in(clk_in), .rst_in(rst_in),
		.ref_clk_in(ref_clk), .gpio_in(gpio), .dpll_locked_in(locked),
		.address_in(addr), .read_in(rd), .write_in(wr),
		.writedata_in(wdata), .readdata_out(rdata),
		.waitrequest_out(wreq),
		.sel_ref_out(sel), .sel_valid_out(selv)
	);
	ref_src ref_src_inst (.half_in(half), .clk_out(ref_clk));

	// ------------------------------
	// Reference model
	// ------------------------------
	function automatic bit elig(int i);
		return val[i] != 0 && man[i] != 0 && prio[i] != 0;
	endfunction
	function automatic int rank(int k);
		int r [$];
		for (int p = 1; p < 16; p++)
			for (int i = 0; i < 3; i++)
				if (elig(i) && prio[i] == p)
					r.push_back(i + 1);
		return (k < r.size()) ? r[k] : 0;
	endfunction
	// Keeps a usable reference unless revertive_select finds a better one
	function automatic int pick();
		int b;
		int j;
		b = rank(0);
		if (b == 0)
			return 0;
		if (cur != 0 && elig(cur - 1) && !(rev != 0 && prio[b - 1] < prio[cur - 1]))
			return cur;
		for (int k = 1; k < 4; k++)
		begin
			j = (cur + k - 1) % 3;
			if (elig(j) && prio[j] == prio[b - 1])
				return j + 1;
		end
		return 0;
	endfunction
	function automatic logic [7:0] tab();
		return {2'(rank(0)), 2'(cur), 2'(rank(1)), 2'(rank(2))};
	endfunction

	// ------------------------------
	// Bus, stimulus and compares
	// ------------------------------
	task automatic bus(input bit w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] r);
		addr <= a;
		wdata <= d;
		rd <= !w;
		wr <= w;
		gpio[3:2] <= 2'($random(seed));
		@(posedge clk_in);
		while (wreq !== 1'b0)
			@(posedge clk_in);
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic put_ctrl();
		logic [31:0] v;
		v = {24'h0, 1'(rev), 1'(psw), 1'b0, 5'(pct)};
		for (int i = 0; i < 3; i++)
			v[8 * i + 8 +: 8] = {1'(los[i]), 3'b001, 1'(man[i]),
				{2{1'(mon[i])}}, 1'(lock_edge_polarity >> i)};
		bus(1'b1, OFF_CTRL, v, q);
	endtask
	task automatic put_prio();
		bus(1'b1, OFF_PRIO, {16'd100, 4'h0, 4'(prio[2]), 4'(prio[1]),
			4'(prio[0])}, q);
	endtask
	task automatic put(input int i, input int h, input int v);
		half[i] <= 16'(h);
		val[i] = v;
	endtask
	task automatic cmp_reg(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		checks_done++;
		if (s !== e)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cmp_sel();
		checks_done++;
		if (sel !== 2'(cur) || selv !== (cur != 0))
		begin
			mismatches++;
			$display("mismatch sel expected %0d seen %h %b", cur, sel, selv);
		end
	endtask
	// Waits for the model's choice, or holds the full span to show no switch
	task automatic expect_sel(input int maxc, input bit hold);
		cur = pick();
		for (int n = 0; n < maxc && (hold || sel !== 2'(cur)); n++)
			@(posedge clk_in);
		cmp_sel();
	endtask
	task automatic print_verdict();
		if (mismatches == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ------------------------------
	// Scenarios
	// ------------------------------
	initial
	begin
		#10_000_000;
		mismatches++;
		print_verdict();
	end
	initial
	begin
		pct = 3 + {$random(seed)} % 18;
		lock_edge_polarity = $random(seed);
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		bus(1'b0, OFF_CTRL, 32'h0, q);
		cmp_reg("ctrl", 32'h08080805, q & 32'h0909091f);
		bus(1'b0, OFF_PRIO, 32'h0, q);
		cmp_reg("prio", 32'h00640321, q & 32'hffff0fff);
		bus(1'b0, OFF_TABLE, 32'h0, q);
		cur = pick();
		cmp_reg("table", {24'h0, tab()}, q);
		cmp_sel();
		bus(1'b0, 4'h3, 32'h0, q);
		cmp_reg("unmapped", 32'h0, q);
		put_ctrl();
		put_prio();
		bus(1'b1, OFF_TABLE, 32'h00002000, q);
		expect_sel(6000, 1'b0);
		bus(1'b0, OFF_TABLE, 32'h0, q);
		cmp_reg("table", {24'h20, tab()}, q);
		bus(1'b0, OFF_STATUS, 32'h0, q);
		cmp_reg("status", 32'h0700001c, q & 32'h0700001c);
		bus(1'b1, OFF_STATUS, 32'h0000001c, q);
		bus(1'b0, OFF_STATUS, 32'h0, q);
		cmp_reg("latched", 32'h0, q & 32'h1c);
		put(0, 0, 0);
		expect_sel(6000, 1'b0);
		put(0, 500, 1);
		expect_sel(6000, 1'b1);
		bus(1'b0, OFF_TABLE, 32'h0, q);
		cmp_reg("table", {24'h20, tab()}, q);
		rev = 1;
		put_ctrl();
		cur = pick();
		rev = 0;
		put_ctrl();
		expect_sel(100, 1'b0);
		rev = 1;
		put_ctrl();
		put(0, 0, 0);
		expect_sel(6000, 1'b0);
		put(0, 500, 1);
		expect_sel(6000, 1'b0);
		man[0] = 0;
		put_ctrl();
		expect_sel(100, 1'b0);
		man[1] = 0;
		put_ctrl();
		expect_sel(100, 1'b0);
		put(2, 250, 0);
		expect_sel(6000, 1'b0);
		mon[2] = 0;
		val[2] = 1;
		put_ctrl();
		expect_sel(6000, 1'b0);
		put(2, 500, 1);
		mon[2] = 1;
		man = '{1, 1, 1};
		put_ctrl();
		expect_sel(6000, 1'b0);
		los[0] = 1;
		put_ctrl();
		gpio[1] <= 1'b1;
		val[0] = 0;
		expect_sel(100, 1'b0);
		gpio[1] <= 1'b0;
		val[0] = 1;
		expect_sel(6000, 1'b0);
		prio[0] = 0;
		put_prio();
		expect_sel(100, 1'b0);
		prio = '{1, 1, 1};
		put_prio();
		expect_sel(3000, 1'b1);
		put(1, 0, 0);
		expect_sel(6000, 1'b0);
		put(1, 500, 1);
		expect_sel(6000, 1'b1);
		psw = 1;
		put_ctrl();
		put(2, 0, 0);
		repeat (2500) @(posedge clk_in);
		cmp_sel();
		psw = 0;
		put_ctrl();
		expect_sel(100, 1'b0);
		put(2, 500, 1);
		expect_sel(6000, 1'b1);
		locked <= 1'b0;
		bus(1'b1, OFF_TABLE, 32'h00c82000, q);
		val = '{0, 0, 0};
		expect_sel(3000, 1'b0);
		bus(1'b0, OFF_STATUS, 32'h0, q);
		cmp_reg("timeouts", 32'he0000000, q & 32'he7000000);
		print_verdict();
	end
endmodule
`default_nettype wire
